// ### tb_top.sv
// Purpose: register and frame level test of the tributary bus framer
// Assumes: partner runs the bus, bench is the Avalon master
// Notes: a 650 ns tributary clock is slow for the E1 in SPE1
`timescale 1ns/1ns
`default_nettype none
`include "tdmf_defines.svh"
module tb_top;
   logic clock, rst, read, write, addPl, addV5, busClk, framePulse, tribClk;
   logic [3:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [7:0] dropPayload, dropData, addData;
   logic waitrequest, dropPl, dropV5, addJust, alarm;
   logic justPrev = 1'b0;
   int errors = 0;
   int cmpCount = 0;
   int justRises = 0;
   int v5Seen = 0;
   tdmf_bus_partner #(.START(9520), .TRIB_HALF(325)) far_u (
      .busReferenceClock(busClk), .inputFramePulse(framePulse),
      .tributaryClock(tribClk), .addData(addData),
      .addPayloadValidIndicator(addPl), .addTributaryV5Indicator(addV5));
   tdmf_framer dut_u (.clock(clock), .rst(rst), .busReferenceClock(busClk),
      .inputFramePulse(framePulse), .tributaryClock(tribClk),
      .addData(addData), .addPayloadValidIndicator(addPl),
      .addTributaryV5Indicator(addV5), .dropPayload(dropPayload),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .dropData(dropData),
      .dropPayloadValidIndicator(dropPl),
      .dropTributaryV5Indicator(dropV5), .addJustRequest(addJust),
      .tributaryAlarmFlag(alarm));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (errors == 0 && cmpCount > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // Request held until an edge samples waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
         n++;
         if (n > 50) begin
            errors++;
            print_verdict();
         end
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_pulse();
      int n;
      n = 0;
      while (framePulse !== 1'b1) begin
         @(posedge clock);
         n++;
         if (n > 70000) begin
            errors++;
            print_verdict();
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      justPrev <= addJust;
      if (addJust === 1'b1 && justPrev === 1'b0) justRises++;
      if (dropV5 === 1'b1) v5Seen++;
      if (!rst && dropPl === 1'b1) check({24'h0, dropData}, 32'hA5);
   end
   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      dropPayload = 8'hA5;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check({19'h0, dropData, dropPl, dropV5, addJust, alarm, waitrequest},
         32'h1);
      check(readdata, 32'h0);
      bus(1'b0, `TDMF_REG_CTRL, 32'h0);
      check(rd, 32'h01FF);
      bus(1'b1, 4'h2, 32'hFFFFFFFF);
      bus(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, `TDMF_REG_CTRL, 32'h1309);
      bus(1'b0, `TDMF_REG_CTRL, 32'h0);
      check(rd, 32'h1309);
      wait_pulse();
      repeat (650) @(posedge clock);
      bus(1'b0, `TDMF_REG_STAT, 32'h0);
      check({24'h0, rd[15:9], 1'(rd[8:0] inside {[9'h068:9'h06C]})},
         32'h83);
      bus(1'b1, `TDMF_REG_JUST, 32'h40);
      bus(1'b0, `TDMF_REG_JUST, 32'h0);
      check({20'h0, rd[11:0]}, 32'h40);
      wait_pulse();
      repeat (20) @(posedge clock);
      bus(1'b0, `TDMF_REG_RATE, 32'h0);
      check({30'h0, rd[9:8]}, 32'h2);
      check({29'h0, rd[12:10]}, 32'h7);
      check({31'h0, alarm}, 32'h1);
      bus(1'b0, `TDMF_REG_JUST, 32'h0);
      check({29'h0, rd[8:6]}, 32'h0);
      check({31'h0, justRises > 0}, 32'h1);
      check({31'h0, v5Seen > 0}, 32'h1);
      bus(1'b1, `TDMF_REG_CTRL, 32'h1709);
      repeat (100) @(posedge clock);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire

// ### tdmf_bus_partner.sv
// Purpose: far side of the tributary bus, reference timing and add octets
// Assumes: bus clock from whole ns steps, 52 ns, near the nominal rate
// Notes: START sets where in the frame the bus begins
`timescale 1ns/1ns
`default_nettype none
module tdmf_bus_partner
   import tdmf_pkg::*;
#(
   parameter int START = 0,
   parameter int TRIB_HALF = 325
)
(
   output logic busReferenceClock,
   output logic inputFramePulse,
   output logic tributaryClock,
   output logic [7:0] addData,
   output logic addPayloadValidIndicator,
   output logic addTributaryV5Indicator
);
   int pos = START;
   int col;
   initial begin
      busReferenceClock = 1'b0;
      forever #26 busReferenceClock = ~busReferenceClock;
   end
   initial begin
      tributaryClock = 1'b0;
      forever #(TRIB_HALF) tributaryClock = ~tributaryClock;
   end
   ////////////////////////////////////////////////////////////////////////
   // Octets change mid-period so the rising edge sees settled data
   always @(negedge busReferenceClock) begin
      pos <= (pos == 9719) ? 0 : pos + 1;
   end
   assign col = pos % 270 + 1;
   assign inputFramePulse = (pos == 6);
   assign addPayloadValidIndicator = (col >= 19);
   assign addTributaryV5Indicator = (pos >= 102 && pos <= 185);
   assign addData = pos[7:0];
endmodule // tdmf_bus_partner
`default_nettype wire

// ### tdmf_defines.svh
// Purpose: offsets, field positions, reset values and counts of the framer
// Assumes: included by its bare name
// Notes: definitions only
`ifndef TDMF_DEFINES_SVH
`define TDMF_DEFINES_SVH
// Avalon byte addresses
`define TDMF_REG_CTRL 4'h0
`define TDMF_REG_STAT 4'h4
`define TDMF_REG_JUST 4'h8
`define TDMF_REG_RATE 4'hC
// Control fields
`define TDMF_CTRL_W 15
`define TDMF_CTRL_RST 15'h01FF
`define TDMF_CTRL_ALMEN 9
`define TDMF_CTRL_SYNC 10
`define TDMF_CTRL_LMASTER 11
`define TDMF_CTRL_RATEEN 12
`define TDMF_CTRL_MSEL 13
// Pending justification fields
`define TDMF_JUST_W 12
`define TDMF_JUST_DADV 0
`define TDMF_JUST_DRET 3
`define TDMF_JUST_AADV 6
`define TDMF_JUST_ARET 9
// Frame geometry
`define TDMF_COLS 9'h10E
`define TDMF_ROWS 4'h9
`define TDMF_C1_COL 9'h007
`define TDMF_SPE_COL 9'h010
`define TDMF_T1_TRIBS 7'h1C
`define TDMF_E1_TRIBS 7'h15
`define TDMF_H3_ROW 4'h3
`define TDMF_LR_ROW 4'h4
`define TDMF_V3_SUB 2'h2
`define TDMF_V4_SUB 2'h3
// Nominal tributary clocks per frame pulse period
`define TDMF_NOM_T1 16'h0304
`define TDMF_NOM_E1 16'h0400
`define TDMF_NOM_DS3 16'h5760
`define TDMF_NOM_E3 16'h4320
`endif

// ### tdmf_framer.sv
// Purpose: tributary bus frame timing, justification and link rate octets
// Assumes: bus pins are sampled by the 125 MHz system clock
// Notes: Avalon-MM slave with waitrequest, word registers
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "tdmf_defines.svh"

// Function
// - Frame pulse marks C1, row 1 column 7
// - Payload only in SPE columns 16-270
// - Three independent SPEs, one type each
// - Columns 16-18 empty for VT-sized types
// - T1 tributaries repeat every 84 columns
// - E1 tributaries repeat every 63 columns
// - Everything timed to bus clock, frame pulse
// - Fast source sends extra octet in V3/H3
// - Slow source leaves octet after V3/H3 empty
// - Drop timing always sourced by the PHY
// - Link master: PHY times from arrivals
// - Speed-up request high during V3/H3
// - Slow-down request high after V3/H3
// - Synchronous mode fixes V5, no floating
// - Link rate optional, never for transparent VTs
// - T1/E1 clock count code 00/01/1x
// - Phase is bus edges to tributary edge
// - DS3/E3 rate octet: alarm, 0, code
// - DS3/E3 code steps of four clocks; here the code only tells equal, more or fewer than nominal
// - Alarm bit high means alarm present
// - Alarm passes through, supported types only
module tdmf_framer
   import tdmf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic busReferenceClock,
   input wire logic inputFramePulse,
   input wire logic tributaryClock,
   input wire logic [7:0] addData,
   input wire logic addPayloadValidIndicator,
   input wire logic addTributaryV5Indicator,
   input wire logic [7:0] dropPayload,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [7:0] dropData,
   output logic dropPayloadValidIndicator,
   output logic dropTributaryV5Indicator,
   output logic addJustRequest,
   output logic tributaryAlarmFlag
);
   tdmf_state_type s_q, s_d;
   logic [1:0] clockCountCode;
   logic [7:0] phase;
   logic busTick;
   logic frameEvt;
   logic tribTick;
   logic [15:0] nominal;
   tdmf_trib_type measType;

   ////////////////////////////////////////////////////////////////////////
   // Per-SPE helpers
   // Selector value 3 is not an SPE and decodes as unused

   function automatic tdmf_trib_type speType(input logic [14:0] c,
                                             input logic [1:0] sel);
      logic [2:0] f;
      f = 3'h0;
      case (sel)
         2'h0: f = c[2:0];
         2'h1: f = c[5:3];
         2'h2: f = c[8:6];
         default: f = 3'h7;
      endcase
      return tdmf_trib_type'(f);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Rate measurement of the selected tributary

   always_comb begin
      measType = speType(s_q.ctrl, s_q.ctrl[`TDMF_CTRL_MSEL +: 2]);
      case (measType)
         TRIB_T1: nominal = `TDMF_NOM_T1;
         TRIB_E1: nominal = `TDMF_NOM_E1;
         TRIB_DS3: nominal = `TDMF_NOM_DS3;
         TRIB_E3: nominal = `TDMF_NOM_E3;
         default: nominal = 16'h0000;
      endcase
   end

   // One meter serves the selected SPE; a meter per SPE would triple the
   // counters for a figure that software reads one SPE at a time
   tdmf_rate_meter meter (
      .clock(clock),
      .rst(rst),
      .busTick(busTick),
      .frameEvt(frameEvt),
      .tribTick(tribTick),
      .nominal(nominal),
      .clockCountCode(clockCountCode),
      .phase(phase)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      tdmf_trib_type t;
      logic vt, transparent_virtual_tributary, ds, sync;
      logic [6:0] w;
      logic firstCol, secondCol, row1, inSpe;
      logic jAdv, jRet, lrOct, v5Oct, base, pl;
      logic [2:0] spe1h;
      logic [9:0] addS;
      logic [7:0] lrByte;
      t = TRIB_NONE;
      vt = 1'b0;
      transparent_virtual_tributary = 1'b0;
      ds = 1'b0;
      sync = 1'b0;
      w = 7'h00;
      firstCol = 1'b0;
      secondCol = 1'b0;
      row1 = 1'b0;
      inSpe = 1'b0;
      jAdv = 1'b0;
      jRet = 1'b0;
      lrOct = 1'b0;
      v5Oct = 1'b0;
      base = 1'b0;
      pl = 1'b0;
      spe1h = 3'h0;
      addS = 10'h000;
      lrByte = 8'h00;
      s_d = s_q;

      // Pins pass three flops; a level counts once stages two and three
      // agree, which also rejects single-sample glitches
      // Limitation: tributary clocks above about 30 MHz alias here
      s_d.clkSync = {s_q.clkSync[1:0], busReferenceClock};
      s_d.fpSync = {s_q.fpSync[1:0], inputFramePulse};
      s_d.tribSync = {s_q.tribSync[1:0], tributaryClock};
      // Add octets share the depth so they line up with the rise event
      s_d.addSync[0] = {addPayloadValidIndicator, addTributaryV5Indicator,
                        addData};
      s_d.addSync[1] = s_q.addSync[0];
      s_d.addSync[2] = s_q.addSync[1];
      if (s_q.clkSync[1] == s_q.clkSync[2]) begin
         s_d.clkLvl = s_q.clkSync[2];
      end
      if (s_q.fpSync[1] == s_q.fpSync[2]) begin
         s_d.fpLvl = s_q.fpSync[2];
      end
      if (s_q.tribSync[1] == s_q.tribSync[2]) begin
         s_d.tribLvl = s_q.tribSync[2];
      end
      busTick = s_d.clkLvl & ~s_q.clkLvl;
      tribTick = s_d.tribLvl & ~s_q.tribLvl;
      frameEvt = busTick & s_d.fpLvl;
      addS = s_q.addSync[2];

      // Octet position, forced to C1 when the pulse is seen
      // Free running between pulses; a lost pulse keeps the old alignment
      if (frameEvt) begin
         s_d.sub = 2'h0;
         s_d.row = 4'h1;
         s_d.col = `TDMF_C1_COL;
         s_d.locked = 1'b1;
      end else if (busTick) begin
         if (s_q.col == `TDMF_COLS) begin
            s_d.col = 9'h001;
            if (s_q.row == `TDMF_ROWS) begin
               s_d.row = 4'h1;
               s_d.sub = s_q.sub + 2'h1;
            end else begin
               s_d.row = s_q.row + 4'h1;
            end
         end else begin
            s_d.col = s_q.col + 9'h001;
         end
      end
      // SPE number varies fastest, then the SPE column
      // SPE column index steps once per three octets from column 16
      if (busTick) begin
         if (s_d.col == `TDMF_SPE_COL) begin
            s_d.speSel = 2'h0;
            s_d.speIdx = 7'h00;
         end else if (s_q.speSel == 2'h2) begin
            s_d.speSel = 2'h0;
            s_d.speIdx = s_q.speIdx + 7'h01;
         end else begin
            s_d.speSel = s_q.speSel + 2'h1;
         end
      end

      // Decode the octet now on the bus
      t = speType(s_q.ctrl, s_d.speSel);
      inSpe = s_d.col >= `TDMF_SPE_COL;
      vt = (t == TRIB_T1) | (t == TRIB_E1) | (t == TRIB_TVT15) |
           (t == TRIB_TVT2);
      transparent_virtual_tributary = (t == TRIB_TVT15) | (t == TRIB_TVT2);
      ds = (t == TRIB_DS3) | (t == TRIB_E3);
      sync = s_q.ctrl[`TDMF_CTRL_SYNC] & ((t == TRIB_T1) | (t == TRIB_E1));
      w = ((t == TRIB_T1) | (t == TRIB_TVT15)) ? `TDMF_T1_TRIBS :
          `TDMF_E1_TRIBS;
      firstCol = (s_d.speIdx != 7'h00) && (s_d.speIdx <= w);
      secondCol = (s_d.speIdx > w) && (s_d.speIdx <= (w << 1));
      row1 = s_d.row == 4'h1;
      spe1h = 3'h1 << s_d.speSel;
      // Justification octets of VT-sized and DS3/E3 maps
      jAdv = inSpe & ((vt & row1 & (s_d.sub == `TDMF_V3_SUB) & firstCol) |
             (ds & (s_d.row == `TDMF_H3_ROW) & (s_d.speIdx == 7'h00)));
      jRet = inSpe & ((vt & row1 & (s_d.sub == `TDMF_V3_SUB) & secondCol) |
             (ds & (s_d.row == `TDMF_H3_ROW) & (s_d.speIdx == 7'h01)));
      // No justification for T1/E1 in synchronous mode
      jAdv = jAdv & ~sync;
      jRet = jRet & ~sync;
      // Link rate octet: V4 for T1/E1, after H3 for DS3/E3
      lrOct = inSpe & ((vt & ~transparent_virtual_tributary & row1 & (s_d.sub == `TDMF_V4_SUB) &
              firstCol) | (ds & (s_d.row == `TDMF_LR_ROW) &
              (s_d.speIdx == 7'h00)));
      // V5 held in the octet following V1
      v5Oct = inSpe & vt & row1 & (s_d.sub == 2'h0) & secondCol;
      base = inSpe & (t != TRIB_NONE) & ~(vt & (s_d.speIdx == 7'h00)) &
             ~(vt & row1 & firstCol) & ~(ds & (s_d.speIdx == 7'h00));
      // column 16-18 excluded above for VT-sized maps
      // Fixed overhead octets never carry payload, whatever is pending

      if (busTick) begin
         // Drop side: this device sets the timing
         pl = base;
         if (jAdv && s_q.pend[`TDMF_JUST_DADV + s_d.speSel]) begin
            pl = 1'b1;
            s_d.pend[`TDMF_JUST_DADV + s_d.speSel] = 1'b0;
         end
         if (jRet && s_q.pend[`TDMF_JUST_DRET + s_d.speSel]) begin
            pl = 1'b0;
            s_d.pend[`TDMF_JUST_DRET + s_d.speSel] = 1'b0;
         end
         // Rate octet carries the code only for the measured SPE
         // Other SPEs send a zero code, which reads as nominal
         if (s_q.ctrl[`TDMF_CTRL_RATEEN] && !transparent_virtual_tributary &&
             (s_d.speSel == s_q.ctrl[`TDMF_CTRL_MSEL +: 2])) begin
            lrByte[5:4] = clockCountCode;
            lrByte[3:0] = ds ? 4'h0 : phase[3:0];
         end
         // Alarm passes unchanged; zero when not supported
         lrByte[7] = s_q.ctrl[`TDMF_CTRL_ALMEN] & ~transparent_virtual_tributary &
                     |(s_q.almCap & spe1h);
         lrByte[6] = 1'b0;
         s_d.dropPl = pl;
         s_d.dropData = pl ? dropPayload : (lrOct ? lrByte : 8'h00);
         s_d.dropV5 = v5Oct;

         // Add side, PHY as timing master
         s_d.addJust = 1'b0;
         if (!s_q.ctrl[`TDMF_CTRL_LMASTER]) begin
            if (jAdv && s_q.pend[`TDMF_JUST_AADV + s_d.speSel]) begin
               s_d.addJust = 1'b1;
               s_d.pend[`TDMF_JUST_AADV + s_d.speSel] = 1'b0;
            end
            if (jRet && s_q.pend[`TDMF_JUST_ARET + s_d.speSel]) begin
               s_d.addJust = 1'b1;
               s_d.pend[`TDMF_JUST_ARET + s_d.speSel] = 1'b0;
            end
         end else begin
            // Link master: timing taken from arrivals
            // Counters wrap; software reads them as running totals
            if (jAdv && addS[9]) begin
               s_d.advCount = s_q.advCount + 8'h01;
            end
            if (jRet && !addS[9]) begin
               s_d.retCount = s_q.retCount + 8'h01;
            end
         end
         // Capture the alarm bit of the incoming rate octet
         if (lrOct && !transparent_virtual_tributary) begin
            s_d.almCap = (s_q.almCap & ~spe1h) | (addS[7] ? spe1h : 3'h0);
         end
      end
      // A one-hot mask keeps selector value 3 from indexing past the flags
      s_d.alarmOut = s_q.ctrl[`TDMF_CTRL_ALMEN] &
                     |(s_q.almCap & (3'h1 << s_q.ctrl[`TDMF_CTRL_MSEL +: 2]));

      ////////////////////////////////////////////////////////////////////
      // Avalon slave: answer one cycle after the request, act at release
      // One wait state keeps readdata registered; an access takes two cycles
      // and a write lands on the edge that samples waitrequest low

      s_d.waitReq = 1'b1;
      if ((read || write) && s_q.waitReq) begin
         s_d.waitReq = 1'b0;
         s_d.rdata = 32'h00000000;
         if (read) begin
            case (address)
               `TDMF_REG_CTRL: s_d.rdata[14:0] = s_q.ctrl;
               `TDMF_REG_STAT: s_d.rdata = {16'h0000, s_q.locked, s_q.sub,
                  s_q.row, s_q.col};
               `TDMF_REG_JUST: s_d.rdata = {s_q.retCount, s_q.advCount,
                  4'h0, s_q.pend};
               `TDMF_REG_RATE: s_d.rdata = {16'h0000, 3'h0, s_q.almCap,
                  clockCountCode, phase};
               default: s_d.rdata = 32'h00000000;
            endcase
         end
      end else if (write && !s_q.waitReq) begin
         case (address)
            `TDMF_REG_CTRL: s_d.ctrl = writedata[14:0];
            // Set after the hardware clear so a new request is kept
            `TDMF_REG_JUST: s_d.pend = s_d.pend | writedata[11:0];
            default: s_d.pend = s_d.pend;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   // Position starts at row 1, column 1 until the first pulse aligns it

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctrl <= `TDMF_CTRL_RST;
         s_q.waitReq <= 1'b1;
         s_q.row <= 4'h1;
         s_q.col <= 9'h001;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata = s_q.rdata;
   assign waitrequest = s_q.waitReq;
   assign dropData = s_q.dropData;
   assign dropPayloadValidIndicator = s_q.dropPl;
   assign dropTributaryV5Indicator = s_q.dropV5;
   assign addJustRequest = s_q.addJust;
   assign tributaryAlarmFlag = s_q.alarmOut;
endmodule // tdmf_framer
`default_nettype wire

// ### tdmf_framer_chk.sv
// Purpose: port level checks of the tributary bus framer
// Assumes: bound to tdmf_framer, one clock domain
// Notes: control word shadowed from completed Avalon writes
`timescale 1ns/1ns
`default_nettype none
`include "tdmf_defines.svh"
module tdmf_framer_chk
   import tdmf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [7:0] dropData,
   input wire logic dropPayloadValidIndicator,
   input wire logic addJustRequest,
   input wire logic tributaryAlarmFlag
);
   logic [14:0] ctrl_q;
   logic [14:0] ctrlOld_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // A second copy lags by one edge, which covers the alarm flag but not flags held for a whole bus octet
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q <= `TDMF_CTRL_RST;
         ctrlOld_q <= `TDMF_CTRL_RST;
      end else begin
         ctrlOld_q <= ctrl_q;
         if (write && !waitrequest && address == `TDMF_REG_CTRL) begin
            ctrl_q <= writedata[14:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_answer;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered in one cycle");
   property p_single;
      !waitrequest |=> waitrequest;
   endproperty
   a_single: assert property (p_single)
      else $error("answer longer than one cycle");
   property p_unmapped;
      read && waitrequest && address[1:0] != 2'h0 |=> readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_dropHold;
      $changed(dropData) |=> $stable(dropData)[*4];
   endproperty
   a_dropHold: assert property (p_dropHold)
      else $error("drop octet shorter than a bus octet");
   property p_plHold;
      $changed(dropPayloadValidIndicator) |=>
         $stable(dropPayloadValidIndicator)[*4];
   endproperty
   a_plHold: assert property (p_plHold)
      else $error("payload flag shorter than a bus octet");
   property p_justLen;
      $rose(addJustRequest) |-> addJustRequest[*5] ##[1:3] !addJustRequest;
   endproperty
   a_justLen: assert property (p_justLen)
      else $error("request not one bus octet long");
   property p_alarmOff;
      !ctrl_q[9] && !ctrlOld_q[9] |-> !tributaryAlarmFlag;
   endproperty
   a_alarmOff: assert property (p_alarmOff)
      else $error("alarm shown while disabled");
   property p_syncNoJust;
      ctrl_q[10] && ctrlOld_q[10] |-> !addJustRequest;
   endproperty
   a_syncNoJust: assert property (p_syncNoJust)
      else $error("justification in synchronous mode");
   property p_nonePl;
      ctrl_q[8:0] == 9'h1FF && ctrlOld_q[8:0] == 9'h1FF
         |-> !dropPayloadValidIndicator;
   endproperty
   a_nonePl: assert property (p_nonePl)
      else $error("payload flagged with all envelopes unused");
endmodule // tdmf_framer_chk
bind tdmf_framer tdmf_framer_chk chk_u (.clock(clock), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .dropData(dropData),
   .dropPayloadValidIndicator(dropPayloadValidIndicator),
   .addJustRequest(addJustRequest),
   .tributaryAlarmFlag(tributaryAlarmFlag));
`default_nettype wire

// ### tdmf_pkg.sv
// Purpose: types shared by the tributary bus framer
// Assumes: nothing
// Notes: constants live in tdmf_defines.svh
package tdmf_pkg;
   typedef enum logic [2:0] {TRIB_T1, TRIB_E1, TRIB_TVT15, TRIB_TVT2,
      TRIB_DS3, TRIB_E3, TRIB_FRAC, TRIB_NONE} tdmf_trib_type;
   typedef struct packed {
      logic [15:0] count;
      logic [7:0] phaseCount;
      logic phaseRun;
      logic [1:0] code;
      logic [7:0] phase;
   } tdmf_meter_type;
   typedef struct packed {
      logic [2:0] clkSync;
      logic [2:0] fpSync;
      logic [2:0] tribSync;
      logic [2:0][9:0] addSync;
      logic clkLvl;
      logic fpLvl;
      logic tribLvl;
      logic [1:0] sub;
      logic [3:0] row;
      logic [8:0] col;
      logic [1:0] speSel;
      logic [6:0] speIdx;
      logic locked;
      logic [14:0] ctrl;
      logic [11:0] pend;
      logic [7:0] advCount;
      logic [7:0] retCount;
      logic [2:0] almCap;
      logic waitReq;
      logic [31:0] rdata;
      logic [7:0] dropData;
      logic dropPl;
      logic dropV5;
      logic addJust;
      logic alarmOut;
   } tdmf_state_type;
endpackage

// ### tdmf_rate_meter.sv
// Purpose: tributary clock count and phase against the frame pulse
// Assumes: ticks are one-cycle events on the system clock
// Notes: count compared with the nominal figure at each frame event
`timescale 1ns/1ns
`default_nettype none
module tdmf_rate_meter
   import tdmf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic busTick,
   input wire logic frameEvt,
   input wire logic tribTick,
   input wire logic [15:0] nominal,
   output logic [1:0] clockCountCode,
   output logic [7:0] phase
);
   tdmf_meter_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (frameEvt) begin
         // Nominal 00, more 01, fewer 10
         if (s_q.count == nominal) begin
            s_d.code = 2'h0;
         end else if (s_q.count > nominal) begin
            s_d.code = 2'h1;
         end else begin
            s_d.code = 2'h2;
         end
         s_d.count = 16'h0000;
         s_d.phaseCount = 8'h00;
         s_d.phaseRun = 1'b1;
      end else begin
         if (tribTick) begin
            s_d.count = s_q.count + 16'h0001;
         end
         if (s_q.phaseRun && busTick) begin
            s_d.phaseCount = s_q.phaseCount + 8'h01;
         end
      end
      // Bus edges from frame pulse to next tributary edge
      if (tribTick && s_q.phaseRun && !frameEvt) begin
         s_d.phase = s_q.phaseCount;
         s_d.phaseRun = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign clockCountCode = s_q.code;
   assign phase = s_q.phase;
endmodule // tdmf_rate_meter
`default_nettype wire
